// >>> rtl/fsh_defines.vh
// register map, field positions, reset values and counts for the fault supervisor
// assumes a 32-bit apb slave with byte addresses and one word per register
`ifndef FSH_DEFINES_VH
`define FSH_DEFINES_VH

// register byte offsets
`define FSH_CTRL_OFS 8'h00
`define FSH_STAT_OFS 8'h04
`define FSH_REF_OFS 8'h08

// control register fields and reset value
`define FSH_CTRL_EN_BIT 0
`define FSH_CTRL_RST 1'b1

// status register fields
`define FSH_ST_STATE_LSB 0
`define FSH_ST_FAIL_LSB 3
`define FSH_ST_PG_BIT 6
`define FSH_ST_UV_BIT 7
`define FSH_ST_OV_BIT 8
`define FSH_ST_OC_BIT 9
`define FSH_ST_BLANK_BIT 10
`define FSH_ST_CROW_BIT 11
`define FSH_ST_PIN_BIT 12
`define FSH_ST_START_BIT 13

// reference register fields
`define FSH_REF_CUR_LSB 0
`define FSH_REF_TGT_LSB 8

// phase-clock counts and the overcurrent failure limit
`define FSH_SS_CYCLES 12'd2048
`define FSH_WAIT_CYCLES 12'd2048
`define FSH_MAX_FAIL 3'd7
`define FSH_REF_STEP_TICKS 1'b1

// identification code that requests shutdown
`define FSH_VID_OFF 5'h1F

`endif

// >>> rtl/fsh_sync.v
// two-flop synchroniser for a group of independent level inputs
// assumes every bit is a slow level, no bus coherence is needed
`default_nettype none

module fsh_sync #(
	parameter WIDTH = 1
) (
	input wire clk,
	input wire rst_n,
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;

	// first stage feeds only the second stage
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= {WIDTH{1'b0}};
			sync_q <= {WIDTH{1'b0}};
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule

`default_nettype wire

// >>> rtl/fsh_supervisor.v
// fault supervisor: power-good, pwm tri-state / low drive, crowbar, hiccup retries
// assumes comparator results and the phase clock arrive as asynchronous levels
//
// The APB interface to the registers and the address map are this design's own decisions.
`default_nettype none
`include "fsh_defines.vh"

// What this block does
// - power-good low from reset, high above undervolt
// - soft-start power-good needs no overcurrent fault
// - once high, drops only on undervolt or fault
// - undervolt threshold tracks reference plus offset
// - undervolt drops power-good, switching continues
// - on disable, power-good holds until undervolt
// - overvolt drops power-good immediately
// - overvolt drives pwm low until reference, then tri-state
// - recurring overvolt drives pwm low again
// - overvolt asserts crowbar gate output
// - overvolt latches off until enable or bias reset
// - overcurrent compare shuts converter down
// - overcurrent tri-states, waits 2048 ticks, restarts
// - overcurrent active during soft-start, restarts wait
// - seven retries, eighth failure latches off
// - overcurrent latch cleared by enable or bias only
// - good soft-start resumes, clears failure count
// - overcurrent ignored while reference is moving
// - start needs bias, enable, freq-select, valid code
// - soft-start timed by eleven-bit phase counter
// - reference steps one code every two ticks
module fsh_supervisor #(
	parameter [11:0] SS_CYCLES = `FSH_SS_CYCLES,
	parameter [11:0] WAIT_CYCLES = `FSH_WAIT_CYCLES
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire phase_clk_in,
	input wire por_ok_in,
	input wire enable_ok_in,
	input wire freq_select_disable_in,
	input wire [4:0] voltage_id_code,
	input wire undervolt_flag,
	input wire overvolt_flag,
	input wire overcurrent_flag,
	input wire at_reference_in,
	input wire power_ok_i,
	output wire power_ok_o,
	output wire power_ok_oe,
	output wire pwm_tristate_out,
	output wire pwm_low_out,
	output wire crowbar_gate_out,
	output wire [4:0] reference_code_out
);

	// supervisor states
	localparam [2:0] ST_SHUT = 3'd0;
	localparam [2:0] ST_SS = 3'd1;
	localparam [2:0] ST_RUN = 3'd2;
	localparam [2:0] ST_WAIT = 3'd3;
	localparam [2:0] ST_OCL = 3'd4;
	localparam [2:0] ST_OVL = 3'd5;

	localparam [11:0] SS_LAST = SS_CYCLES - 12'd1;
	localparam [11:0] WAIT_LAST = WAIT_CYCLES - 12'd1;

	// synchronised pin levels
	wire [13:0] raw_w, sync_w;
	wire ph_s, por_s, en_s, fsd_s, uv_s, ov_s, oc_s, atref_s, pin_s;
	wire [4:0] vid_s;

	// comparator and control inputs all pass two flops first
	assign raw_w = {phase_clk_in, por_ok_in, enable_ok_in, freq_select_disable_in,
		undervolt_flag, overvolt_flag, overcurrent_flag, at_reference_in,
		power_ok_i, voltage_id_code};

	fsh_sync #(
		.WIDTH(14)
	) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.async_in(raw_w),
		.sync_out(sync_w)
	);

	// undervolt_flag high means sense plus offset sits above the reference
	assign {ph_s, por_s, en_s, fsd_s} = sync_w[13:10];
	assign {uv_s, ov_s, oc_s, atref_s, pin_s, vid_s} = sync_w[9:0];

	// registers
	reg ph_prev_q, ctrl_en_q, step_q;
	reg [2:0] state_q, state_d, fail_q, fail_d;
	reg [10:0] cnt_q, cnt_d;
	reg [4:0] ref_q, tgt_q, vid_prev_q;
	reg ovlow_q, ovlow_d, pg_q, pg_d;
	reg pg_oe_q, pg_o_q, hiz_q, low_q, crow_q, pready_q, pslverr_q;
	reg [31:0] prdata_q;

	wire tick, start_ok, rst_cond, blank, oc_eff, acc;

	// one pulse per phase-clock rising edge
	assign tick = ph_s & ~ph_prev_q;

	// bias, enable, freq-select not grounded, code not the off code
	assign start_ok = por_s & en_s & fsd_s & (vid_s != `FSH_VID_OFF) & ctrl_en_q;

	// only enable or bias loss clears a latched fault
	assign rst_cond = ~por_s | ~en_s;

	// overcurrent blanked while the reference is still stepping
	assign blank = (ref_q != tgt_q);
	assign oc_eff = oc_s & ~blank;

	// step one code from cur toward dst
	function [4:0] step_toward;
		input [4:0] cur;
		input [4:0] dst;
		begin
			if (dst > cur) begin
				step_toward = cur + 5'd1;
			end else if (dst < cur) begin
				step_toward = cur - 5'd1;
			end else begin
				step_toward = cur;
			end
		end
	endfunction

	// phase edge history
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph_prev_q <= 1'b0;
		end else begin
			ph_prev_q <= ph_s;
		end
	end

	// reference tracker: new code must hold one tick, then steps every two ticks
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_q <= 5'h00;
			tgt_q <= 5'h00;
			vid_prev_q <= 5'h00;
			step_q <= 1'b0;
		end else if (state_q == ST_SHUT) begin
			ref_q <= vid_s;
			tgt_q <= vid_s;
			vid_prev_q <= vid_s;
			step_q <= 1'b0;
		end else if (tick) begin
			vid_prev_q <= vid_s;
			if (vid_s == vid_prev_q) begin
				tgt_q <= vid_s;
			end
			if (ref_q != tgt_q) begin
				step_q <= ~step_q;
				if (step_q == `FSH_REF_STEP_TICKS) begin
					ref_q <= step_toward(ref_q, tgt_q);
				end
			end else begin
				step_q <= 1'b0;
			end
		end
	end

	// supervisor next state
	always @* begin
		state_d = state_q;
		cnt_d = cnt_q;
		fail_d = fail_q;
		if (state_q == ST_OVL) begin
			// stays latched while overvolt persists or until reset condition
			if (rst_cond && !ov_s) begin
				state_d = ST_SHUT;
				fail_d = 3'd0;
			end
		end else if (ov_s) begin
			state_d = ST_OVL;
			cnt_d = 11'd0;
		end else begin
			case (state_q)
				ST_SHUT: begin
					fail_d = 3'd0;
					cnt_d = 11'd0;
					if (start_ok) begin
						state_d = ST_SS;
					end
				end
				ST_SS: begin
					if (!start_ok) begin
						state_d = ST_SHUT;
					end else if (oc_eff) begin
						cnt_d = 11'd0;
						if (fail_q == `FSH_MAX_FAIL) begin
							state_d = ST_OCL;
						end else begin
							fail_d = fail_q + 3'd1;
							state_d = ST_WAIT;
						end
					end else if (tick) begin
						if ({1'b0, cnt_q} == SS_LAST) begin
							state_d = ST_RUN;
							fail_d = 3'd0;
							cnt_d = 11'd0;
						end else begin
							cnt_d = cnt_q + 11'd1;
						end
					end
				end
				ST_RUN: begin
					if (!start_ok) begin
						state_d = ST_SHUT;
					end else if (oc_eff) begin
						cnt_d = 11'd0;
						if (fail_q == `FSH_MAX_FAIL) begin
							state_d = ST_OCL;
						end else begin
							fail_d = fail_q + 3'd1;
							state_d = ST_WAIT;
						end
					end
				end
				ST_WAIT: begin
					if (!start_ok) begin
						state_d = ST_SHUT;
					end else if (tick) begin
						if ({1'b0, cnt_q} == WAIT_LAST) begin
							state_d = ST_SS;
							cnt_d = 11'd0;
						end else begin
							cnt_d = cnt_q + 11'd1;
						end
					end
				end
				ST_OCL: begin
					if (rst_cond) begin
						state_d = ST_SHUT;
					end
				end
				default: begin
					state_d = ST_SHUT;
				end
			endcase
		end
	end

	// overvolt low drive: set by overvolt, released at reference level
	always @* begin
		ovlow_d = ovlow_q;
		if (state_d != ST_OVL) begin
			ovlow_d = 1'b0;
		end else if (ov_s) begin
			ovlow_d = 1'b1;
		end else if (atref_s) begin
			ovlow_d = 1'b0;
		end
	end

	// power-good level by state
	always @* begin
		case (state_d)
			ST_SS: pg_d = uv_s;
			ST_RUN: pg_d = uv_s;
			ST_SHUT: pg_d = pg_q & uv_s;
			default: pg_d = 1'b0;
		endcase
	end

	// state, counters and output flops
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_SHUT;
			cnt_q <= 11'd0;
			fail_q <= 3'd0;
			ovlow_q <= 1'b0;
			pg_q <= 1'b0;
			pg_oe_q <= 1'b1;
			pg_o_q <= 1'b0;
			hiz_q <= 1'b1;
			low_q <= 1'b0;
			crow_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			fail_q <= fail_d;
			ovlow_q <= ovlow_d;
			pg_q <= pg_d;
			// open drain: enable pulls low, released means high
			pg_oe_q <= ~pg_d;
			pg_o_q <= 1'b0;
			low_q <= ovlow_d;
			hiz_q <= ~ovlow_d & (state_d != ST_SS) & (state_d != ST_RUN);
			crow_q <= (state_d == ST_OVL);
		end
	end

	// apb: one wait state, answer registered
	assign acc = psel & penable & ~pready_q;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= acc;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
			if (acc) begin
				if (paddr == `FSH_CTRL_OFS) begin
					prdata_q[`FSH_CTRL_EN_BIT] <= ctrl_en_q;
				end else if (paddr == `FSH_STAT_OFS) begin
					prdata_q[`FSH_ST_STATE_LSB +: 3] <= state_q;
					prdata_q[`FSH_ST_FAIL_LSB +: 3] <= fail_q;
					prdata_q[`FSH_ST_PG_BIT] <= pg_q;
					prdata_q[`FSH_ST_UV_BIT] <= uv_s;
					prdata_q[`FSH_ST_OV_BIT] <= ov_s;
					prdata_q[`FSH_ST_OC_BIT] <= oc_s;
					prdata_q[`FSH_ST_BLANK_BIT] <= blank;
					prdata_q[`FSH_ST_CROW_BIT] <= crow_q;
					prdata_q[`FSH_ST_PIN_BIT] <= pin_s;
					prdata_q[`FSH_ST_START_BIT] <= start_ok;
				end else if (paddr == `FSH_REF_OFS) begin
					prdata_q[`FSH_REF_CUR_LSB +: 5] <= ref_q;
					prdata_q[`FSH_REF_TGT_LSB +: 5] <= tgt_q;
				end else begin
					pslverr_q <= 1'b1;
				end
			end
		end
	end

	// control register write at the completing edge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_en_q <= `FSH_CTRL_RST;
		end else if (psel && penable && pready_q && pwrite && paddr == `FSH_CTRL_OFS) begin
			ctrl_en_q <= pwdata[`FSH_CTRL_EN_BIT];
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign power_ok_o = pg_o_q;
	assign power_ok_oe = pg_oe_q;
	assign pwm_tristate_out = hiz_q;
	assign pwm_low_out = low_q;
	assign crowbar_gate_out = crow_q;
	assign reference_code_out = ref_q;

endmodule

`default_nettype wire

// >>> testbench/fsh_sva_assertions.sv
// checker of the supervisor fault outputs, bound to its top module
// assumes pin levels reach the outputs three clock edges later
`default_nettype none
module fsh_sva (
	input wire pclk,
	input wire presetn,
	input wire por_ok_in,
	input wire enable_ok_in,
	input wire freq_select_disable_in,
	input wire [4:0] voltage_id_code,
	input wire undervolt_flag,
	input wire overvolt_flag,
	input wire overcurrent_flag,
	input wire power_ok_oe,
	input wire pwm_tristate_out,
	input wire pwm_low_out,
	input wire crowbar_gate_out,
	input wire [4:0] reference_code_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// overvoltage reactions and latch
	a_ov_pg_low: assert property (
		$rose(overvolt_flag) |-> ##[1:4] power_ok_oe) else $error("pg high on ov");
	a_ov_crowbar: assert property (
		$rose(overvolt_flag) |-> ##[1:4] crowbar_gate_out && pwm_low_out) else $error("no crowbar");
	a_ov_latch: assert property (
		crowbar_gate_out && enable_ok_in && por_ok_in |=> crowbar_gate_out) else $error("latch lost");
	a_low_not_tri: assert property (
		pwm_low_out |-> !pwm_tristate_out) else $error("low and tri together");
	// power-good against undervolt and faults
	a_uv_pg_low: assert property (
		!undervolt_flag [*4] |-> power_ok_oe) else $error("pg high below uv");
	a_pg_holds: assert property (
		(undervolt_flag && !overvolt_flag && !overcurrent_flag) [*4] ##0 !power_ok_oe
		|=> !power_ok_oe) else $error("pg dropped without fault");
	// overcurrent trip and start conditions
	a_oc_trips: assert property (
		(overcurrent_flag && reference_code_out == voltage_id_code) [*4] ##0 !pwm_tristate_out
		|=> pwm_tristate_out || pwm_low_out) else $error("oc not tripped");
	a_start_gate: assert property (
		(voltage_id_code == 5'h1F || !freq_select_disable_in || !enable_ok_in || !por_ok_in) [*4]
		|-> pwm_tristate_out || pwm_low_out) else $error("runs while disabled");
	// main scenarios reached
	c_crowbar: cover property ($rose(crowbar_gate_out));
	c_hiccup: cover property ($rose(pwm_tristate_out) && !pwm_low_out);
	c_pg_up: cover property ($fell(power_ok_oe));
endmodule
bind fsh_supervisor fsh_sva u_sva (.pclk, .presetn, .por_ok_in, .enable_ok_in,
	.freq_select_disable_in, .voltage_id_code, .undervolt_flag, .overvolt_flag,
	.overcurrent_flag, .power_ok_oe, .pwm_tristate_out, .pwm_low_out, .crowbar_gate_out,
	.reference_code_out);
`default_nettype wire

// >>> testbench/fsh_plant.sv
// model of the power-good wire seen by the system monitor
// assumes a pull-up and only the supervisor pulling low
`default_nettype none
module fsh_plant (
	input wire logic power_ok_o,
	input wire logic power_ok_oe,
	output logic power_ok_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// pull-up wins unless the open drain pulls
	assign power_ok_i = power_ok_oe ? power_ok_o : 1'b1;
endmodule
`default_nettype wire

// >>> testbench/fault_supervisor_hiccup_tb_top.sv
// bench for the fault supervisor: apb master, fault stimulus, checks
// assumes soft-start and wait counts shortened to 8 ticks
`default_nettype none
module fault_supervisor_hiccup_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, phase_clk_in = 0;
	logic por_ok_in = 1, enable_ok_in = 1, freq_select_disable_in = 1, undervolt_flag = 1;
	logic overvolt_flag = 0, overcurrent_flag = 0, at_reference_in = 0, perr;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, rd;
	logic [4:0] voltage_id_code = 5'h03;
	wire [31:0] prdata;
	wire [4:0] reference_code_out;
	wire pready, pslverr, power_ok_o, power_ok_oe, power_ok_i;
	wire pwm_tristate_out, pwm_low_out, crowbar_gate_out;
	integer seed = 32'h96c54ac2;
	int n_errors = 0, checks = 0, cyc = 0, hp = 2, pc = 0, m_st = 0, pv = 0;
	fsh_supervisor #(.SS_CYCLES(12'd8), .WAIT_CYCLES(12'd8)) u_dut (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .phase_clk_in,
		.por_ok_in, .enable_ok_in, .freq_select_disable_in, .voltage_id_code, .undervolt_flag,
		.overvolt_flag, .overcurrent_flag, .at_reference_in, .power_ok_i, .power_ok_o,
		.power_ok_oe, .pwm_tristate_out, .pwm_low_out, .crowbar_gate_out, .reference_code_out);
	fsh_plant u_plant (.power_ok_o, .power_ok_oe, .power_ok_i);
	// clock
	always #4 pclk = ~pclk;
	// phase clock and hang guard
	always @(posedge pclk) begin
		pc <= (pc >= hp) ? 0 : pc + 1;
		if (pc >= hp) phase_clk_in <= ~phase_clk_in;
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_errors++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s exp %0h seen %0h", nm, exp, seen);
		end
	endtask
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		// wait as long as the slave needs; only the bench timeout ends a hang
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		perr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// poll status until the model state shows
	task automatic wait_st(input int s);
		int k;
		k = 0;
		m_st = s;
		do begin
			apb(0, 8'h04, 0);
			k++;
		end while (rd[2:0] !== m_st[2:0] && k < 1000);
		chk("state", rd[2:0], m_st);
	endtask
	// main sequence
	initial begin
		hp = 2 + ($random(seed) & 3);
		voltage_id_code <= 5'($random(seed)) & 5'h0F;
		repeat (6) @(posedge pclk);
		presetn <= 1;
		chk("pg rst", power_ok_i, 0);
		apb(0, 8'h00, 0);
		chk("ctrl", rd, 1);
		apb(1, 8'h0C, 0);
		chk("slverr", perr, 1);
		wait_st(1);
		chk("pg ss", power_ok_i, 1);
		chk("ref", reference_code_out, voltage_id_code);
		wait_st(2);
		undervolt_flag <= 0;
		repeat (5) @(posedge pclk);
		chk("pg uv", power_ok_i, 0);
		chk("tri uv", pwm_tristate_out, 0);
		undervolt_flag <= 1;
		overcurrent_flag <= 1;
		repeat (5) @(posedge pclk);
		chk("tri oc", pwm_tristate_out, 1);
		wait_st(4);
		chk("fails", rd[5:3], 7);
		overcurrent_flag <= 0;
		apb(0, 8'h04, 0);
		chk("latched", rd[2:0], 4);
		enable_ok_in <= 0;
		wait_st(0);
		enable_ok_in <= 1;
		wait_st(2);
		chk("fails clr", rd[5:3], 0);
		overvolt_flag <= 1;
		repeat (5) @(posedge pclk);
		chk("crowbar", crowbar_gate_out, 1);
		chk("pg ov", power_ok_i, 0);
		overvolt_flag <= 0;
		at_reference_in <= 1;
		repeat (5) @(posedge pclk);
		chk("ov tri", {pwm_low_out, pwm_tristate_out}, 1);
		overvolt_flag <= 1;
		repeat (5) @(posedge pclk);
		chk("ov again", pwm_low_out, 1);
		overvolt_flag <= 0;
		wait_st(5);
		por_ok_in <= 0;
		wait_st(0);
		por_ok_in <= 1;
		at_reference_in <= 0;
		wait_st(2);
		voltage_id_code <= 5'h1F;
		wait_st(0);
		chk("pg dis", power_ok_i, 1);
		undervolt_flag <= 0;
		freq_select_disable_in <= 0;
		voltage_id_code <= 5'h06;
		repeat (9) @(posedge pclk);
		chk("pg decay", power_ok_i, 0);
		undervolt_flag <= 1;
		freq_select_disable_in <= 1;
		wait_st(2);
		// code step during run: overcurrent is blanked while the reference moves
		voltage_id_code <= 5'h0E;
		do apb(0, 8'h08, 0); while (rd[12:8] !== 5'h0E);
		overcurrent_flag <= 1;
		repeat (5) @(posedge pclk);
		apb(0, 8'h04, 0);
		chk("oc seen", rd[9], 1);
		chk("blank", rd[10], 1);
		chk("oc ignored", rd[2:0], 2);
		overcurrent_flag <= 0;
		pv = reference_code_out;
		// reference moves at most one code between polls, never backwards
		do begin
			apb(0, 8'h08, 0);
			chk("ref step", rd[4:0] - pv[4:0] <= 1, 1);
			pv = rd[4:0];
		end while (pv != 14);
		wait_st(2);
		give_verdict();
	end
endmodule
`default_nettype wire
